// file: logic/mrl_regs.sv
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
`include "mrl_consts.svh"
// Behaviour
// - unmapped modbus addresses read zero; writes acknowledged and change nothing.
// - measurement words read zero before first readings or outside operating mode.
// - settings only in update mode; otherwise zero with illegal-data-address.
// - command words read zero; save outside update mode, or energy reset in update mode, gives illegal-data-address.
// - wrong energy-reset password still answers normally but the reset is dropped; save does not check it.
// - save commits to nonvolatile store; failure answers device-failure and restarts.
// - energy reset in degraded fallback state gives illegal-function.
// - eight limits pick their quantity by modbus address, lowest word of pairs.
// - zero or meaningless limit identifier behaves as an unused limit.
// - high side goes out above setpoint, back below return threshold.
// - low side mirrors this in the opposite direction.
// - setpoints are tenths of a percent of full scale chosen per quantity class.
// - unavailable distortion shows all-ones in every harmonic word of the channel.
// - 2.5 element derives A-B and B-C; missing phase zeroes its voltage angles.
// - A and C current angles always; B only for wye; missing phase zero.
// - any out-of-range setting keeps the meter in degraded fallback state.
// - a mega range figure scales the power full scale by one million.
// - two-word values put the high half at the lower address.
module mrl_regs
#(
  parameter int NLIM = 8
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic [4:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    meas_first,
  input  wire logic [7:0][15:0]        meas_word,
  input  wire logic [31:0]             energy_val,
  input  wire logic [3:0][15:0]        thd_word,
  input  wire logic [1:0]              thd_ok,
  input  wire logic [2:0][15:0]        ang_v_meas,
  input  wire logic [1:0][15:0]        ang_v_calc,
  input  wire logic [2:0][15:0]        ang_i_meas,
  input  wire logic [2:0]              phase_ok,
  input  wire logic                    nv_done,
  input  wire logic                    nv_fail,
  output logic                         nv_save,
  output logic                         energy_reset,
  output logic                         meter_restart,
  output mrl_pkg::mrl_mode_type        mode,
  output logic [NLIM-1:0]              high_side_limit,
  output logic [NLIM-1:0]              low_side_limit
);
  logic [15:0]           setw [0:`MRL_NSET-1];
  mrl_pkg::mrl_fsm_type  fsm;
  mrl_pkg::mrl_req_type  req;
  mrl_pkg::mrl_rsp_type  rsp;
  logic                  ack;
  logic [31:0]           ctrl;
  logic [31:0]           rdata;
  logic                  bus_wr;
  logic [15:0]           cfg;
  logic [1:0]            hookup;
  logic                  set_ok;
  logic [15:0]           ang_all [0:5];
  logic [15:0]           pw_expect;
  mrl_pkg::mrl_sel_type  msel;
  logic                  in_set;
  logic [5:0]            set_idx;
  logic                  is_rd;
  logic                  is_wr;
  logic [7:0]            ex;
  logic [15:0]           word;
  logic                  set_wr;
  logic                  save_go;
  logic                  eres_go;

  assign cfg    = setw[`MRL_SO_CFG];
  assign hookup = cfg[`MRL_CFG_HK +: 2];

  function automatic logic [31:0] mrl_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : mrl_merge

  // voltage angle source and missing phases
  always_comb
  begin
    if (hookup == `MRL_HK_ELEM25)
    begin
      ang_all[0] = ang_v_calc[0];
      ang_all[1] = ang_v_calc[1];
    end
    else
    begin
      ang_all[0] = ang_v_meas[0];
      ang_all[1] = ang_v_meas[1];
    end
    ang_all[2] = ang_v_meas[2];
    if (!phase_ok[0] || !phase_ok[1])
      ang_all[0] = 16'h0000;
    if (!phase_ok[1] || !phase_ok[2])
      ang_all[1] = 16'h0000;
    if (!phase_ok[2] || !phase_ok[0])
      ang_all[2] = 16'h0000;
    ang_all[3] = phase_ok[0] ? ang_i_meas[0] : 16'h0000;
    ang_all[4] = (phase_ok[1] && hookup == `MRL_HK_WYE) ? ang_i_meas[1] : 16'h0000;
    ang_all[5] = phase_ok[2] ? ang_i_meas[2] : 16'h0000;
  end

  // map a modbus address onto the measurement section
  function automatic mrl_pkg::mrl_sel_type mrl_meas(input logic [15:0] a);
    mrl_pkg::mrl_sel_type s;
    logic [15:0]          o;
    s       = '0;
    s.cls   = mrl_pkg::MRL_C_PCT;
    o       = 16'h0000;
    if (a < `MRL_MA_PLAIN)
    begin
      s.hit  = 1'b1;
      s.lim  = 1'b1;
      s.word = meas_word[a[2:0]];
      s.val  = {16'h0000, s.word};
      case (a[2:0])
        3'h0:    s.cls = mrl_pkg::MRL_C_FREQ;
        3'h1:    s.cls = mrl_pkg::MRL_C_PF;
        3'h2:    s.cls = mrl_pkg::MRL_C_PCT;
        3'h3:    s.cls = mrl_pkg::MRL_C_POWER;
        3'h4:    s.cls = mrl_pkg::MRL_C_VOLT;
        3'h5:    s.cls = mrl_pkg::MRL_C_VOLT;
        default: s.cls = mrl_pkg::MRL_C_CURR;
      endcase
    end
    else if (a < `MRL_MA_THD)
    begin
      s.hit = 1'b1;
      s.cls = mrl_pkg::MRL_C_POWER;
      s.val = energy_val;
      s.word = (a == `MRL_MA_ENGY) ? energy_val[31:16] : energy_val[15:0];
      // only the lowest word selects a pair
      s.lim  = (a == `MRL_MA_ENGY);
    end
    else if (a < `MRL_MA_ANG)
    begin
      o     = a - `MRL_MA_THD;
      s.hit = 1'b1;
      s.lim = 1'b1;
      s.word = thd_ok[o[1]] ? thd_word[o[1:0]] : `MRL_THD_NA;
      s.val  = {16'h0000, s.word};
    end
    else if (a < `MRL_MA_END)
    begin
      o      = a - `MRL_MA_ANG;
      s.hit  = 1'b1;
      s.lim  = 1'b1;
      s.cls  = mrl_pkg::MRL_C_ANG;
      s.word = ang_all[o[2:0]];
      s.val  = {16'h0000, s.word};
    end
    return s;
  endfunction : mrl_meas

  always_comb
  begin
    set_ok = (hookup != `MRL_HK_BAD);
    for (int k = 0; k < 8; k++)
    begin
      if (setw[6'(k) + `MRL_SO_HSP] > `MRL_SP_MAX || setw[6'(k) + `MRL_SO_HRT] > `MRL_SP_MAX)
        set_ok = 1'b0;
      if (setw[6'(k) + `MRL_SO_LSP] > `MRL_SP_MAX || setw[6'(k) + `MRL_SO_LRT] > `MRL_SP_MAX)
        set_ok = 1'b0;
    end
    if (setw[`MRL_SO_CT] == 16'h0000 || setw[`MRL_SO_CT] > `MRL_RAT_MAX)
      set_ok = 1'b0;
    if (setw[`MRL_SO_PT] == 16'h0000 || setw[`MRL_SO_PT] > `MRL_RAT_MAX)
      set_ok = 1'b0;
  end

  // fixed password when checking is off
  assign pw_expect = cfg[`MRL_CFG_PWEN] ? setw[`MRL_SO_PW] : `MRL_PW_DEFAULT;

  // request decode, evaluated while the fsm sits in exec
  always_comb
  begin
    msel    = mrl_meas(req.addr);
    set_idx = 6'(req.addr - `MRL_MA_SET);
    in_set  = req.addr >= `MRL_MA_SET && req.addr < `MRL_MA_SET + 16'(`MRL_NSET);
    is_rd   = (req.fc == `MRL_FC_RD);
    is_wr   = (req.fc == `MRL_FC_WR);
    ex      = `MRL_EX_NONE;
    word    = 16'h0000;
    set_wr  = 1'b0;
    save_go = 1'b0;
    eres_go = 1'b0;
    if (!is_rd && !is_wr)
      ex = `MRL_EX_FUNC;
    else if (in_set)
    begin
      if (mode != mrl_pkg::MRL_SETTINGS_UPDATE)
        ex = `MRL_EX_ADDR;
      else if (is_rd)
        word = setw[set_idx];
      else
        set_wr = 1'b1;
    end
    else if (req.addr == `MRL_MA_SAVE || req.addr == `MRL_MA_ERST)
    begin
      // commands read zero, mode checked on write
      if (is_wr && req.addr == `MRL_MA_SAVE)
      begin
        if (mode != mrl_pkg::MRL_SETTINGS_UPDATE)
          ex = `MRL_EX_ADDR;
        else
          save_go = 1'b1;
      end
      else if (is_wr)
      begin
        if (mode == mrl_pkg::MRL_DEGRADED_FALLBACK_STATE)
          ex = `MRL_EX_FUNC;
        else if (mode != mrl_pkg::MRL_OPERATING)
          ex = `MRL_EX_ADDR;
        else if (req.data == pw_expect)
          eres_go = 1'b1;
      end
    end
    // measurement gated by readings and mode
    else if (msel.hit && is_rd && meas_first && mode == mrl_pkg::MRL_OPERATING)
      word = msel.word;
    // anything else reads zero and ignores writes
  end

  // avalon: one wait cycle per access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign bus_wr          = avs_write & ack;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  always_comb
  begin
    case ({avs_address[4:2], 2'b00})
      `MRL_A_CTRL:   rdata = ctrl;
      `MRL_A_STATUS: rdata = {26'h0000000, rsp.done, fsm != mrl_pkg::MRL_IDLE, set_ok, mode};
      `MRL_A_REQ:    rdata = {req.data, req.addr};
      `MRL_A_GO:     rdata = {24'h000000, req.fc};
      `MRL_A_RSP:    rdata = {rsp.code, rsp.fc, rsp.data};
      `MRL_A_LIMITS: rdata = {16'h0000, 8'(low_side_limit), 8'(high_side_limit)};
      default:       rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack)
      avs_readdata <= rdata;
  end

  // settings-update request bit; a failed save drops it
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      ctrl <= 32'h0000_0000;
    else if (fsm == mrl_pkg::MRL_SAVE && nv_fail)
      ctrl[`MRL_CTRL_SETUP] <= 1'b0;
    else if (bus_wr && {avs_address[4:2], 2'b00} == `MRL_A_CTRL && avs_byteenable[0])
      ctrl[`MRL_CTRL_SETUP] <= avs_writedata[`MRL_CTRL_SETUP];
  end

  // request latch; go is refused while a request is in flight
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      req <= '0;
    else if (bus_wr && {avs_address[4:2], 2'b00} == `MRL_A_REQ)
      {req.data, req.addr} <= mrl_merge({req.data, req.addr}, avs_writedata, avs_byteenable);
    else if (bus_wr && {avs_address[4:2], 2'b00} == `MRL_A_GO && fsm == mrl_pkg::MRL_IDLE)
      req.fc <= avs_writedata[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      fsm <= mrl_pkg::MRL_IDLE;
    else
    begin
      case (fsm)
        mrl_pkg::MRL_IDLE:
          if (bus_wr && {avs_address[4:2], 2'b00} == `MRL_A_GO)
            fsm <= mrl_pkg::MRL_EXEC;
        mrl_pkg::MRL_EXEC:
          fsm <= save_go ? mrl_pkg::MRL_SAVE : mrl_pkg::MRL_IDLE;
        mrl_pkg::MRL_SAVE:
          if (nv_done || nv_fail)
            fsm <= mrl_pkg::MRL_IDLE;
        default:
          fsm <= mrl_pkg::MRL_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rsp <= '0;
    else if (fsm == mrl_pkg::MRL_IDLE && bus_wr && {avs_address[4:2], 2'b00} == `MRL_A_GO)
      rsp.done <= 1'b0;
    else if (fsm == mrl_pkg::MRL_EXEC && !save_go)
    begin
      rsp.done <= 1'b1;
      rsp.code <= ex;
      rsp.fc   <= (ex != `MRL_EX_NONE) ? (req.fc | `MRL_EX_BIT) : req.fc;
      rsp.data <= word;
    end
    else if (fsm == mrl_pkg::MRL_SAVE && (nv_done || nv_fail))
    begin
      rsp.done <= 1'b1;
      rsp.code <= nv_fail ? `MRL_EX_FAIL : `MRL_EX_NONE;
      rsp.fc   <= nv_fail ? (req.fc | `MRL_EX_BIT) : req.fc;
      rsp.data <= 16'h0000;
    end
  end

  // settings store; ratios reset to one so the meter starts valid
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `MRL_NSET; i++)
        setw[i] <= 16'h0000;
      setw[`MRL_SO_CT] <= `MRL_RAT_RST;
      setw[`MRL_SO_PT] <= `MRL_RAT_RST;
    end
    else if (fsm == mrl_pkg::MRL_EXEC && set_wr)
      setw[set_idx] <= req.data;
  end

  // command pulses toward the rest of the meter
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      nv_save       <= 1'b0;
      energy_reset  <= 1'b0;
      meter_restart <= 1'b0;
    end
    else
    begin
      nv_save       <= (fsm == mrl_pkg::MRL_EXEC) && save_go;
      energy_reset  <= (fsm == mrl_pkg::MRL_EXEC) && eres_go;
      meter_restart <= (fsm == mrl_pkg::MRL_SAVE) && nv_fail;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      mode <= mrl_pkg::MRL_OPERATING;
    // failed commit leaves update mode by restart
    else if (fsm == mrl_pkg::MRL_SAVE && nv_fail)
      mode <= set_ok ? mrl_pkg::MRL_OPERATING : mrl_pkg::MRL_DEGRADED_FALLBACK_STATE;
    else if (mode == mrl_pkg::MRL_SETTINGS_UPDATE)
    begin
      if (!ctrl[`MRL_CTRL_SETUP] && fsm != mrl_pkg::MRL_SAVE)
        mode <= set_ok ? mrl_pkg::MRL_OPERATING : mrl_pkg::MRL_DEGRADED_FALLBACK_STATE;
    end
    else if (ctrl[`MRL_CTRL_SETUP])
      mode <= mrl_pkg::MRL_SETTINGS_UPDATE;
    // bad settings hold the fallback state
    else
      mode <= set_ok ? mrl_pkg::MRL_OPERATING : mrl_pkg::MRL_DEGRADED_FALLBACK_STATE;
  end

  for (genvar k = 0; k < NLIM; k++)
  begin : g_lim
    mrl_pkg::mrl_sel_type sel;
    logic [47:0]          fs;
    logic [47:0]          ratio;
    logic                 used;
    // process form so the measurement inputs read by the function are watched
    always_comb sel = mrl_meas(setw[k]);
    // zero or meaningless identifier disables the monitor
    assign used  = (setw[k] != 16'h0000) && sel.hit && sel.lim;
    assign ratio = 48'(setw[`MRL_SO_CT] * setw[`MRL_SO_PT]);
    always_comb
    begin
      case (sel.cls)
        mrl_pkg::MRL_C_FREQ: fs = cfg[`MRL_CFG_F50] ? `MRL_FS_F50 : `MRL_FS_F60;
        mrl_pkg::MRL_C_PF:   fs = `MRL_FS_PF;
        mrl_pkg::MRL_C_ANG:  fs = `MRL_FS_ANG;
        mrl_pkg::MRL_C_VOLT: fs = 48'(setw[`MRL_SO_PT]);
        mrl_pkg::MRL_C_CURR: fs = 48'(setw[`MRL_SO_CT]);
        // mega range scales by one million
        mrl_pkg::MRL_C_POWER: fs = cfg[`MRL_CFG_MEGA] ? 48'(ratio * `MRL_MEGA) : ratio;
        default:             fs = `MRL_FS_PCT;
      endcase
    end
    // quantity chosen by the identifier address
    mrl_limit #(
      .VW (32),
      .FW (48)
    ) u_lim (
      .ref_clk         (ref_clk),
      .rstn            (rstn),
      .en              (used),
      .value           (sel.val),
      .fs              (fs),
      .hi_sp           (setw[6'(k) + `MRL_SO_HSP]),
      .hi_rt           (setw[6'(k) + `MRL_SO_HRT]),
      .lo_sp           (setw[6'(k) + `MRL_SO_LSP]),
      .lo_rt           (setw[6'(k) + `MRL_SO_LRT]),
      .high_side_limit (high_side_limit[k]),
      .low_side_limit  (low_side_limit[k])
    );
  end
endmodule : mrl_regs

// file: logic/mrl_consts.svh
`ifndef MRL_CONSTS_SVH
`define MRL_CONSTS_SVH
// avalon byte offsets
`define MRL_A_CTRL      5'h00
`define MRL_A_STATUS    5'h04
`define MRL_A_REQ       5'h08
`define MRL_A_GO        5'h0C
`define MRL_A_RSP       5'h10
`define MRL_A_LIMITS    5'h14
`define MRL_CTRL_SETUP  0
// modbus function and exception codes
`define MRL_FC_RD       8'h03
`define MRL_FC_WR       8'h06
`define MRL_EX_BIT      8'h80
`define MRL_EX_NONE     8'h00
`define MRL_EX_FUNC     8'h01
`define MRL_EX_ADDR     8'h02
`define MRL_EX_FAIL     8'h04
// modbus register map of the meter
`define MRL_MA_PLAIN    16'h0008
`define MRL_MA_ENGY     16'h0008
`define MRL_MA_THD      16'h000A
`define MRL_MA_ANG      16'h000E
`define MRL_MA_END      16'h0014
`define MRL_MA_SET      16'h0100
`define MRL_NSET        48
`define MRL_SO_HSP      6'h08
`define MRL_SO_HRT      6'h10
`define MRL_SO_LSP      6'h18
`define MRL_SO_LRT      6'h20
`define MRL_SO_PW       6'h28
`define MRL_SO_CFG      6'h29
`define MRL_SO_CT       6'h2A
`define MRL_SO_PT       6'h2B
`define MRL_MA_SAVE     16'h0200
`define MRL_MA_ERST     16'h0201
// settings config word bits
`define MRL_CFG_PWEN    0
`define MRL_CFG_F50     1
`define MRL_CFG_MEGA    2
`define MRL_CFG_HK      3
`define MRL_HK_WYE      2'h0
`define MRL_HK_ELEM25   2'h2
`define MRL_HK_BAD      2'h3
// settings ranges and reset values
`define MRL_SP_MAX      16'h07D0
`define MRL_RAT_MAX     16'h270F
`define MRL_RAT_RST     16'h0001
`define MRL_PW_DEFAULT  16'h15B3
`define MRL_THD_NA      16'hFFFF
// full scales, setpoints in tenths of a percent
`define MRL_PCT_SCALE   64'h0000_0000_0000_03E8
`define MRL_FS_F60      48'h0000_0000_0258
`define MRL_FS_F50      48'h0000_0000_01F4
`define MRL_FS_PF       48'h0000_0000_03E8
`define MRL_FS_PCT      48'h0000_0000_03E8
`define MRL_FS_ANG      48'h0000_0000_0708
`define MRL_MEGA        48'h0000_000F_4240
`endif

// file: logic/mrl_pkg.sv
package mrl_pkg;
  typedef enum logic [2:0] {
    MRL_OPERATING               = 3'b001,
    MRL_SETTINGS_UPDATE         = 3'b010,
    MRL_DEGRADED_FALLBACK_STATE = 3'b100
  } mrl_mode_type;
  typedef enum logic [2:0] {
    MRL_IDLE = 3'b001,
    MRL_EXEC = 3'b010,
    MRL_SAVE = 3'b100
  } mrl_fsm_type;
  typedef enum logic [2:0] {
    MRL_C_FREQ = 3'h0, MRL_C_PF = 3'h1, MRL_C_PCT = 3'h2, MRL_C_ANG = 3'h3,
    MRL_C_VOLT = 3'h4, MRL_C_CURR = 3'h5, MRL_C_POWER = 3'h6
  } mrl_cls_type;
  typedef struct packed {
    logic [7:0]  fc;
    logic [15:0] data;
    logic [15:0] addr;
  } mrl_req_type;
  typedef struct packed {
    logic        done;
    logic [7:0]  code;
    logic [7:0]  fc;
    logic [15:0] data;
  } mrl_rsp_type;
  typedef struct packed {
    logic        hit;
    logic        lim;
    mrl_cls_type cls;
    logic [15:0] word;
    logic [31:0] val;
  } mrl_sel_type;
endpackage : mrl_pkg

// file: logic/mrl_limit.sv
`timescale 1ns/1ns
`include "mrl_consts.svh"
module mrl_limit
#(
  parameter int VW = 32,
  parameter int FW = 48
)
(
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          en,
  input  wire logic [VW-1:0] value,
  input  wire logic [FW-1:0] fs,
  input  wire logic [15:0]   hi_sp,
  input  wire logic [15:0]   hi_rt,
  input  wire logic [15:0]   lo_sp,
  input  wire logic [15:0]   lo_rt,
  output logic               high_side_limit,
  output logic               low_side_limit
);
  localparam int PW = 64;
  logic [PW-1:0] v_s;
  logic [PW-1:0] t_hs;
  logic [PW-1:0] t_hr;
  logic [PW-1:0] t_ls;
  logic [PW-1:0] t_lr;

  // value scaled by 1000 so setpoints stay in tenths of a percent of fs
  always_comb
  begin
    v_s  = PW'(value) * `MRL_PCT_SCALE;
    t_hs = PW'(fs) * PW'(hi_sp);
    t_hr = PW'(fs) * PW'(hi_rt);
    t_ls = PW'(fs) * PW'(lo_sp);
    t_lr = PW'(fs) * PW'(lo_rt);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn || !en)
      high_side_limit <= 1'b0;
    else if (!high_side_limit && v_s > t_hs)
      high_side_limit <= 1'b1;
    else if (high_side_limit && v_s < t_hr)
      high_side_limit <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn || !en)
      low_side_limit <= 1'b0;
    else if (!low_side_limit && v_s < t_ls)
      low_side_limit <= 1'b1;
    else if (low_side_limit && v_s > t_lr)
      low_side_limit <= 1'b0;
  end
endmodule : mrl_limit

// file: dv/mrl_regs_monitor.sv
`timescale 1ns/1ns
module mrl_regs_monitor
#(
  parameter int NLIM = 8
)
(
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic                  avs_waitrequest,
  input wire logic                  nv_save,
  input wire logic                  energy_reset,
  input wire logic                  meter_restart,
  input wire mrl_pkg::mrl_mode_type mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  save_mode_a: assert property (nv_save |-> mode == mrl_pkg::MRL_SETTINGS_UPDATE)
    else $error("commit outside update mode");
  save_pulse_a: assert property (nv_save |=> !nv_save)
    else $error("commit pulse too long");
  fail_exit_a: assert property (meter_restart |=> mode != mrl_pkg::MRL_SETTINGS_UPDATE)
    else $error("update mode kept after failure");
  restart_pulse_a: assert property (meter_restart |=> !meter_restart)
    else $error("restart pulse too long");
  fallback_reset_a: assert property (
    mode == mrl_pkg::MRL_DEGRADED_FALLBACK_STATE |=> !energy_reset)
    else $error("energy reset in fallback");
  energy_pulse_a: assert property (energy_reset |=> !energy_reset)
    else $error("energy reset pulse too long");
  mode_hot_a: assert property ($onehot(mode))
    else $error("mode not one-hot");
endmodule : mrl_regs_monitor
bind mrl_regs mrl_regs_monitor #(.NLIM(NLIM)) u_mon (.ref_clk(ref_clk), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .nv_save(nv_save), .energy_reset(energy_reset), .meter_restart(meter_restart), .mode(mode));

// file: dv/mrl_nv_model.sv
`timescale 1ns/1ns
module mrl_nv_model
(
  input wire logic       ref_clk,
  input wire logic       nv_save,
  input wire logic       fail_mode,
  input wire logic [2:0] lat,
  output logic           nv_done,
  output logic           nv_fail
);
  logic [2:0] cnt;
  initial
  begin
    nv_done = 1'b0;
    nv_fail = 1'b0;
    cnt = 3'h0;
  end
  // commit ends in success or failure after lat cycles
  always @(posedge ref_clk)
  begin
    nv_done <= (cnt == 3'h1) && !fail_mode;
    nv_fail <= (cnt == 3'h1) && fail_mode;
    cnt <= nv_save ? lat : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
  end
endmodule : mrl_nv_model

// file: dv/tb_top.sv
`timescale 1ns/1ns
`include "mrl_consts.svh"
module tb_top;
  logic                  ref_clk, rstn, avs_read, avs_write, avs_waitrequest, meas_first;
  logic                  nv_done, nv_fail, nv_save, energy_reset, meter_restart, fail_mode;
  logic [4:0]            avs_address;
  logic [31:0]           avs_writedata, avs_readdata, energy_val, rd, seed;
  logic [7:0][15:0]      meas_word;
  logic [3:0][15:0]      thd_word;
  logic [1:0]            thd_ok;
  logic [2:0][15:0]      ang_v_meas, ang_i_meas;
  logic [1:0][15:0]      ang_v_calc;
  logic [2:0]            phase_ok, lat;
  logic [7:0]            hi, lo;
  logic                  eh, el;
  logic [15:0]           v;
  mrl_pkg::mrl_mode_type mode;
  int                    fail_count, comparisons, erst_n, rst_n;
  mrl_regs dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .meas_first(meas_first), .meas_word(meas_word), .energy_val(energy_val),
    .thd_word(thd_word), .thd_ok(thd_ok), .ang_v_meas(ang_v_meas), .ang_v_calc(ang_v_calc),
    .ang_i_meas(ang_i_meas), .phase_ok(phase_ok), .nv_done(nv_done), .nv_fail(nv_fail),
    .nv_save(nv_save), .energy_reset(energy_reset), .meter_restart(meter_restart),
    .mode(mode), .high_side_limit(hi), .low_side_limit(lo));
  mrl_nv_model nv (.ref_clk(ref_clk), .nv_save(nv_save), .fail_mode(fail_mode), .lat(lat),
    .nv_done(nv_done), .nv_fail(nv_fail));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (energy_reset === 1'b1) erst_n++;
    if (meter_restart === 1'b1) rst_n++;
  end
  function logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  // expected view of the measurement words
  function logic [15:0] em(input logic [15:0] a);
    if (a < 16'h0008) return meas_word[a[2:0]];
    case (a)
      16'h0008: return energy_val[31:16];
      16'h0009: return energy_val[15:0];
      16'h000A, 16'h000B: return `MRL_THD_NA;
      16'h000C, 16'h000D: return thd_word[a[1:0] + 2'h2];
      16'h0010: return ang_v_meas[2];
      16'h0011: return ang_i_meas[0];
      16'h0013: return ang_i_meas[2];
      default: return 16'h0000;
    endcase
  endfunction : em
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task chk_rsp(input logic [7:0] ex, input logic [7:0] fc);
    chk(rd[31:16], {ex, ex != 8'h00 ? fc | `MRL_EX_BIT : fc});
  endtask : chk_rsp
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) fail_count++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task mb(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d);
    int n;
    bus(1'b1, `MRL_A_REQ, {d, a});
    bus(1'b1, `MRL_A_GO, {24'h000000, fc});
    n = 0;
    do
    begin
      bus(1'b0, `MRL_A_STATUS, 32'h0);
      n++;
    end
    while (rd[5] !== 1'b1 && n < 30);
    if (rd[5] !== 1'b1) fail_count++;
    bus(1'b0, `MRL_A_RSP, 32'h0);
  endtask : mb
  task complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end
  initial
  begin
    {rstn, avs_read, avs_write, meas_first, fail_mode} = 5'h00;
    {avs_address, avs_writedata, energy_val, thd_word, ang_v_calc} = '0;
    {meas_word, ang_v_meas, ang_i_meas} = '0;
    {thd_ok, phase_ok, lat} = {2'h2, 3'h5, 3'h1};
    {fail_count, comparisons, erst_n, rst_n} = '0;
    seed = 32'h0000_2B1A;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    mb(`MRL_FC_RD, 16'h0000, 16'h0000);
    chk(rd, 32'h0003_0000);
    mb(`MRL_FC_WR, 16'h0050, 16'h1234);
    chk_rsp(`MRL_EX_NONE, `MRL_FC_WR);
    mb(`MRL_FC_RD, 16'h0050, 16'h0000);
    chk(rd, 32'h0003_0000);
    mb(`MRL_FC_RD, `MRL_MA_ERST, 16'h0000);
    chk(rd[15:0], 16'h0000);
    mb(`MRL_FC_RD, 16'h0108, 16'h0000);
    chk(rd, 32'h0283_0000);
    mb(8'h10, 16'h0000, 16'h0000);
    chk_rsp(`MRL_EX_FUNC, 8'h10);
    meas_first <= 1'b1;
    for (int i = 0; i < 8; i++) meas_word[i] <= xs();
    for (int i = 0; i < 4; i++) thd_word[i] <= xs();
    for (int i = 0; i < 3; i++) {ang_v_meas[i], ang_i_meas[i]} <= {xs(), xs()};
    energy_val <= {xs(), xs()};
    for (logic [15:0] a = 16'h0000; a < `MRL_MA_END; a++)
    begin
      mb(`MRL_FC_RD, a, 16'h0000);
      chk(rd[15:0], em(a));
    end
    mb(`MRL_FC_WR, `MRL_MA_ERST, 16'h1234);
    chk_rsp(`MRL_EX_NONE, `MRL_FC_WR);
    chk(erst_n, 0);
    // with passwords disabled the fixed default is sent
    mb(`MRL_FC_WR, `MRL_MA_ERST, `MRL_PW_DEFAULT);
    chk(erst_n, 1);
    bus(1'b1, `MRL_A_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(mode, mrl_pkg::MRL_SETTINGS_UPDATE);
    mb(`MRL_FC_WR, `MRL_MA_ERST, `MRL_PW_DEFAULT);
    chk_rsp(`MRL_EX_ADDR, `MRL_FC_WR);
    fail_mode <= 1'b1;
    mb(`MRL_FC_WR, `MRL_MA_SAVE, `MRL_PW_DEFAULT);
    chk_rsp(`MRL_EX_FAIL, `MRL_FC_WR);
    chk(rst_n, 1);
    chk(mode, mrl_pkg::MRL_OPERATING);
    bus(1'b1, `MRL_A_CTRL, 32'h1);
    {fail_mode, lat} <= 4'h5;
    mb(`MRL_FC_WR, 16'h0100, 16'h0001);
    mb(`MRL_FC_WR, 16'h0101, 16'h0050);
    mb(`MRL_FC_WR, 16'h0108, 16'h01F4);
    mb(`MRL_FC_WR, 16'h0110, 16'h0190);
    mb(`MRL_FC_WR, 16'h0118, 16'h00C8);
    mb(`MRL_FC_WR, 16'h0120, 16'h012C);
    mb(`MRL_FC_RD, 16'h0108, 16'h0000);
    chk(rd, 32'h0003_01F4);
    mb(`MRL_FC_WR, `MRL_MA_SAVE, `MRL_PW_DEFAULT);
    chk_rsp(`MRL_EX_NONE, `MRL_FC_WR);
    bus(1'b1, `MRL_A_CTRL, 32'h0);
    {eh, el} = 2'b00;
    for (int i = 0; i < 16; i++)
    begin
      v = i == 0 ? 16'h01F5 : i == 1 ? 16'h01F4 : i == 2 ? 16'h00C7 : xs() % 16'h02BC;
      meas_word[1] <= v;
      repeat (4) @(posedge ref_clk);
      eh = v > 16'h01F4 ? 1'b1 : (v < 16'h0190 ? 1'b0 : eh);
      el = v < 16'h00C8 ? 1'b1 : (v > 16'h012C ? 1'b0 : el);
      chk({lo, hi}, {7'h00, el, 7'h00, eh});
    end
    bus(1'b1, `MRL_A_CTRL, 32'h1);
    mb(`MRL_FC_WR, 16'h0129, 16'h0018);
    bus(1'b1, `MRL_A_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(mode, mrl_pkg::MRL_DEGRADED_FALLBACK_STATE);
    mb(`MRL_FC_WR, `MRL_MA_ERST, `MRL_PW_DEFAULT);
    chk_rsp(`MRL_EX_FUNC, `MRL_FC_WR);
    chk(erst_n, 1);
    complete_run();
  end
endmodule : tb_top
